// ---- bench/tcm_agent_model.sv ----
// Management agent model: APB master on the rear bus, counts notifications.
// Assumes the register bank answers on pclk by raising pready.
`timescale 1ns/10ps
module tcm_agent_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB master.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Notifications.
   input wire logic [2:0] trap_pulse
);
   int trap_count [3];
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   always @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!presetn) trap_count[i] <= 0;
         else if (trap_pulse[i] === 1'b1) trap_count[i] <= trap_count[i] + 1;
      end
   end
   // Holds the request until pready is seen at a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

// ---- bench/transport_combiner_mgmt_objects_test.sv ----
// Self-checking bench for the management object register bank.
// Assumes a 10 MHz pclk and the agent model as APB master.
`timescale 1ns/10ps
module transport_combiner_mgmt_objects_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata, wd;
   logic rerr, trunk_present, decomb_major, capping_on, major_alarm, minor_alarm, unit_reset;
   logic [3:0] channel_present, channel_long_packets, channel_carry, channel_led;
   logic [63:0] channel_rate, channel_rate_limit;
   logic [1:0] user_config_switch;
   logic [2:0] trap_pulse;
   logic [15:0] lim [4];
   int bad_count, total_checks, ur_count, t0, t1, t2, tg;
   tcm_agent_model agent (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trap_pulse(trap_pulse));
   tcm_mgmt_regs #(.FLASH_HALF_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel_present(channel_present),
      .channel_long_packets(channel_long_packets), .channel_rate(channel_rate),
      .trunk_present(trunk_present), .decomb_major(decomb_major),
      .user_config_switch(user_config_switch), .channel_carry(channel_carry),
      .capping_on(capping_on), .channel_rate_limit(channel_rate_limit),
      .channel_led(channel_led), .major_alarm(major_alarm), .minor_alarm(minor_alarm),
      .unit_reset(unit_reset), .trap_pulse(trap_pulse));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (unit_reset === 1'b1) ur_count++;
   task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
      total_checks++;
   endtask
   task print_verdict;
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task rd(input logic [7:0] a);
      agent.xfer(1'b0, a, 32'h0000_0000, rdata, rerr);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      agent.xfer(1'b1, a, d, rdata, rerr);
   endtask
   function automatic logic [7:0] ca(input int n, input logic [4:0] o);
      return 8'h40 + 8'h20 * n[7:0] + {3'b000, o};
   endfunction
   function automatic logic [31:0] two(input logic f);
      return f ? 32'h0000_0002 : 32'h0000_0001;
   endfunction
   function automatic logic [31:0] summary(input logic [3:0] p, input logic [63:0] r);
      logic [17:0] s;
      logic mj, mn;
      s = 18'(r[15:0]) + 18'(r[31:16]) + 18'(r[47:32]) + 18'(r[63:48]);
      mj = s > 18'h2_4220;
      mn = p == 4'h0;
      return mj && mn ? 32'h0000_0004 : mj ? 32'h0000_0002 : mn ? 32'h0000_0003 : 32'h0000_0001;
   endfunction
   task settle;
      repeat (6) @(posedge pclk);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      print_verdict;
   end
   initial begin
      void'($urandom(81));
      {presetn, channel_present, channel_long_packets, channel_rate} = '0;
      {trunk_present, decomb_major, user_config_switch} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h04);
      check("capping reset", rdata, 32'h0000_0001);
      rd(8'h0C);
      check("version", rdata, 32'h0000_0100);
      rd(8'h3C);
      check("unmapped", {rerr, rdata}, 33'h0_0000_0000 | 33'h1_0000_0000);
      for (int n = 0; n < 4; n++) begin
         lim[n] = 16'h9088;
         rd(ca(n, 5'h04));
         check("enable reset", rdata, 32'h0000_0002);
         rd(ca(n, 5'h10));
         check("limit reset", rdata, 32'h0000_9088);
      end
      for (int s = 0; s < 4; s++) begin
         user_config_switch <= 2'(s);
         settle;
         rd(8'h08);
         check("coding", rdata, s < 2 ? 1 : s == 3 ? 2 : 3);
      end
      for (int it = 0; it < 8; it++) begin
         channel_present <= it == 0 ? 4'h0 : it == 1 ? 4'hf : 4'($urandom);
         channel_long_packets <= 4'($urandom);
         trunk_present <= 1'($urandom);
         decomb_major <= 1'($urandom);
         for (int n = 0; n < 4; n++) begin
            channel_rate[16*n +: 16] <= it < 2 ? 16'h9088 + 16'(it == 1 && n == 0)
               : 16'($urandom_range(0, 60000));
            if (it == 3) begin
               wd = $urandom_range(1000, 37000);
               lim[n] = wd[15:0];
               wr(ca(n, 5'h10), wd);
               rd(ca(n, 5'h10));
               check("limit", rdata, wd);
               check("limit out", channel_rate_limit[16*n +: 16], lim[n]);
            end
         end
         settle;
         wd = summary(channel_present, channel_rate);
         rd(8'h00);
         check("summary", rdata, wd);
         check("major", major_alarm, wd == 2 || wd == 4);
         check("minor", minor_alarm, channel_present == 4'h0);
         rd(8'h1C);
         check("trunk", rdata, two(trunk_present));
         for (int n = 0; n < 4; n++) begin
            rd(ca(n, 5'h00));
            check("presence", rdata, two(channel_present[n]));
            rd(ca(n, 5'h08));
            check("packet", rdata, two(channel_long_packets[n]));
            rd(ca(n, 5'h0C));
            check("rate", rdata, {16'h0000, channel_rate[16*n +: 16]});
            rd(ca(n, 5'h14));
            check("rate alarm", rdata, two(channel_rate[16*n +: 16] > lim[n]));
         end
      end
      wr(8'h04, 32'h0000_0002);
      wr(8'h04, 32'h0000_0003);
      rd(8'h04);
      check("capping", {capping_on, rdata}, 33'h1_0000_0002);
      channel_present <= 4'hf;
      wr(ca(0, 5'h04), 32'h0000_0001);
      settle;
      rd(ca(0, 5'h04));
      check("disable", {channel_carry, rdata}, 36'he_0000_0001);
      tg = 0;
      repeat (20) begin
         wd[0] = channel_led[0];
         @(posedge pclk);
         if (channel_led[0] !== wd[0]) tg++;
      end
      check("led flash", tg > 0, 1'b1);
      wr(ca(0, 5'h04), 32'h0000_0002);
      check("enable", channel_carry, 4'hf);
      wd = $urandom;
      for (int k = 0; k < 4; k++) wr(8'hE0 + 8'(4 * k), wd + 32'(k));
      for (int k = 0; k < 4; k++) begin
         rd(8'hE0 + 8'(4 * k));
         check("alias", rdata, k == 3 ? {8'h00, 24'(wd + 32'h0000_0003)} : wd + 32'(k));
      end
      wr(ca(0, 5'h10), 32'h0000_1000);
      channel_rate <= 64'h0;
      wr(8'h14, 32'h0000_002A);
      settle;
      wr(8'h18, 32'h0000_0007);
      {t0, t1, t2} = {agent.trap_count[0], agent.trap_count[1], agent.trap_count[2]};
      channel_rate[15:0] <= 16'hffff;
      for (int n = 0; n < 4; n++) begin
         channel_present[n] <= 1'b0;
         @(posedge pclk);
      end
      settle;
      check("alarm trap", agent.trap_count[0] - t0, 1);
      check("rate trap", agent.trap_count[1] - t1, 1);
      check("presence trap", agent.trap_count[2] - t2, 4);
      rd(8'h18);
      check("events", rdata, 32'h0000_0007);
      wr(8'h14, 32'h0000_0015);
      {t0, t2} = {agent.trap_count[0], agent.trap_count[2]};
      channel_present <= 4'h1;
      settle;
      check("traps off", {agent.trap_count[0] - t0, agent.trap_count[2] - t2}, 0);
      tg = ur_count;
      wr(8'h10, 32'h0000_0002);
      repeat (30) @(posedge pclk);
      check("unit reset", ur_count - tg, 16);
      rd(8'h10);
      check("unit reset read", rdata, 32'h0000_0000);
      print_verdict;
   end
endmodule

// ---- shared/tcm_pkg.sv ----
// Constants for the transport combiner management object set.
// Assumes APB access with 32-bit data and a 10 MHz pclk.
package tcm_pkg;
   localparam int unsigned NUM_CHANNELS = 4;
   localparam int unsigned ALIAS_BYTES = 15;
   localparam int unsigned ALIAS_WORDS = 4;
   localparam int unsigned RATE_WIDTH = 16;
   localparam int unsigned VERSION_WIDTH = 8;

   // Enumerated object values.
   localparam logic [2:0] ALARM_FREE = 3'h1;
   localparam logic [2:0] MAJOR_CLASS_ACTIVE = 3'h2;
   localparam logic [2:0] MINOR_CLASS_ACTIVE = 3'h3;
   localparam logic [2:0] BOTH_ALARM_CLASSES_ACTIVE = 3'h4;
   localparam logic [1:0] VAL_OFF = 2'h1;
   localparam logic [1:0] VAL_ON = 2'h2;
   localparam logic [1:0] SHORT_PACKET_LENGTH = 2'h1;
   localparam logic [1:0] LONG_PACKET_LENGTH = 2'h2;
   localparam logic [1:0] CODING_MARK_INVERSION = 2'h1;
   localparam logic [1:0] INVERTED_LEVEL_CODING = 2'h2;
   localparam logic [1:0] PLAIN_LEVEL_CODING = 2'h3;
   localparam logic [31:0] UNIT_RESET_KEY = 32'h0000_0002;

   // Total payload limit in kb/s units of the rate fields.
   localparam logic [RATE_WIDTH+1:0] TOTAL_RATE_LIMIT = 18'h2_4220;

   // Reset values.
   localparam logic [1:0] RESET_ENABLE = 2'h2;
   localparam logic [1:0] RESET_CAP = 2'h1;
   localparam logic [1:0] RESET_TRAP = 2'h1;
   localparam logic [RATE_WIDTH-1:0] RESET_RATE_LIMIT = 16'h9088;

   // Front-panel flash: 250 ms half period at 10 MHz.
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned CLOCK_KHZ = 10000;
   localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * CLOCK_KHZ;
   localparam int unsigned UNIT_RESET_CYCLES = 16;

   // Register byte offsets.
   localparam logic [7:0] OFS_ALARM_SUMMARY = 8'h00;
   localparam logic [7:0] OFS_CAPPING = 8'h04;
   localparam logic [7:0] OFS_CODING = 8'h08;
   localparam logic [7:0] OFS_VERSION = 8'h0C;
   localparam logic [7:0] OFS_UNIT_RESET = 8'h10;
   localparam logic [7:0] OFS_TRAP_ENABLE = 8'h14;
   localparam logic [7:0] OFS_TRAP_EVENTS = 8'h18;
   localparam logic [7:0] OFS_TRUNK = 8'h1C;
   localparam logic [7:0] OFS_CHANNEL_BASE = 8'h40;
   localparam logic [7:0] CHANNEL_STRIDE = 8'h20;
   localparam logic [7:0] OFS_ALIAS_BASE = 8'hC0;
   // Offsets inside a channel window.
   localparam logic [4:0] CH_PRESENCE = 5'h00;
   localparam logic [4:0] CH_ENABLE = 5'h04;
   localparam logic [4:0] CH_PACKET = 5'h08;
   localparam logic [4:0] CH_RATE = 5'h0C;
   localparam logic [4:0] CH_RATE_LIMIT = 5'h10;
   localparam logic [4:0] CH_RATE_ALARM = 5'h14;
   localparam logic [4:0] CH_ALIAS = 5'h18;
   localparam logic [1:0] ALIAS_WORD_FIELD = 2'h3;

   // Trap event bit positions.
   localparam int unsigned TRAP_ALARM_BIT = 0;
   localparam int unsigned TRAP_RATE_BIT = 1;
   localparam int unsigned TRAP_PRESENCE_BIT = 2;

   function automatic logic [1:0] two_state(input logic flag);
      two_state = flag ? VAL_ON : VAL_OFF;
   endfunction
endpackage

// ---- verilog/tcm_change_detect.sv ----
// Detects any change of a level vector and pulses for one cycle.
// Assumes the vector is already in the pclk domain.
`timescale 1ns/10ps
module tcm_change_detect #(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Watched levels and event.
   input wire logic [WIDTH-1:0] level,
   output logic changed
);
   logic [WIDTH-1:0] last;
   logic primed;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= '0;
         primed <= 1'b0;
      end else begin
         last <= level;
         primed <= 1'b1;
      end
   end

   // The first cycle after reset reports nothing.
   assign changed = primed && (last != level);
endmodule

// ---- verilog/tcm_flash_divider.sv ----
// Slow enable divider and blink phase for front-panel indicators.
// Assumes a single pclk domain.
`timescale 1ns/10ps
module tcm_flash_divider #(
   parameter int unsigned HALF_CYCLES = tcm_pkg::FLASH_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Blink phase.
   output logic phase
);
   logic [31:0] count;
   wire logic wrap = (count == 32'(HALF_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         phase <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + 32'h0000_0001;
         if (wrap) begin
            phase <= ~phase;
         end
      end
   end
endmodule

// ---- verilog/tcm_mgmt_regs.sv ----
// Management object register bank for a four-channel stream combiner card.
// Assumes an APB master on pclk; status inputs come from pins and are synchronised here.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
// Contract
// - Alarm summary reads 1 none, 2 urgent, 3 non-urgent, 4 both.
// - Combiner capping control writable, 1 disabled, 2 enabled, read back.
// - Per-channel presence reads 1 absent, 2 present.
// - Per-channel enable held, 1 disabled, 2 enabled, gates carriage.
// - Disabled channel with signal present flashes its indicator.
// - Packet length reads 1 for 188 bytes, 2 for 204 bytes.
// - Per-channel approximate measured rate is reported.
// - Combiner holds writable per-channel maximum rate.
// - Rate alarm reads 2 when measured rate exceeds its limit.
// - Per-channel alias of up to 15 bytes, read and write.
// - Line-coding switch reads 1 CMI, 2 inverted NRZ, 3 NRZ.
// - Logic version reported as major and minor numbers.
// - Writing 2 to unit reset triggers full reset and clears up-time.
// - Unit reset register always reads zero.
// - Alarm trap on assert and clear when enable is 2.
// - Rate alarm trap on assert and clear when enabled.
// - Presence trap on each presence change when enabled; changes on several channels in the same cycle give a single trap.
// - Decombiner reports trunk input presence, 1 absent, 2 present.
// - Combiner urgent alarm when summed rate exceeds 148 Mb/s.
// - Combiner non-urgent alarm when no input carries a valid stream.
module tcm_mgmt_regs #(
   parameter bit IS_COMBINER = 1'b1,
   parameter logic [7:0] VERSION_MAJOR = 8'h01,
   parameter logic [7:0] VERSION_MINOR = 8'h00,
   parameter int unsigned FLASH_HALF_CYCLES = tcm_pkg::FLASH_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel status from the stream datapath.
   input wire logic [3:0] channel_present,
   input wire logic [3:0] channel_long_packets,
   input wire logic [63:0] channel_rate,
   input wire logic trunk_present,
   input wire logic decomb_major,
   input wire logic [1:0] user_config_switch,
   // Controls toward the datapath and panel.
   output logic [3:0] channel_carry,
   output logic capping_on,
   output logic [63:0] channel_rate_limit,
   output logic [3:0] channel_led,
   output logic major_alarm,
   output logic minor_alarm,
   output logic unit_reset,
   // Notifications toward the management agent.
   output logic [2:0] trap_pulse
);
   localparam int unsigned RW = tcm_pkg::RATE_WIDTH;

   // Two-stage synchronisers for pin-side status.
   logic [73:0] sync_a;
   logic [73:0] sync_b;
   wire logic [73:0] raw_in = {channel_present, channel_long_packets, channel_rate,
                                trunk_present, decomb_major};
   logic [1:0] switch_a;
   logic [1:0] switch_b;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= '0;
         sync_b <= '0;
         switch_a <= '0;
         switch_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
         switch_a <= user_config_switch;
         switch_b <= switch_a;
      end
   end
   wire logic [3:0] present_s = sync_b[73:70];
   wire logic [3:0] long_s = sync_b[69:66];
   wire logic [63:0] rate_s = sync_b[65:2];
   wire logic trunk_s = sync_b[1];
   wire logic dmajor_s = sync_b[0];

   // Held settings.
   logic [3:0] enable_reg;
   logic capping;
   logic [RW-1:0] limit_reg [tcm_pkg::NUM_CHANNELS];
   logic [31:0] alias_mem [tcm_pkg::NUM_CHANNELS * tcm_pkg::ALIAS_WORDS];
   logic [1:0] trap_en [3];
   logic [2:0] trap_events;
   logic [4:0] reset_count;

   // APB decode.
   wire logic wr_fire = psel && penable && pwrite;
   wire logic rd_fire = psel && penable && !pwrite;
   wire logic is_alias = paddr >= tcm_pkg::OFS_ALIAS_BASE;
   wire logic in_chan = (paddr >= tcm_pkg::OFS_CHANNEL_BASE) && !is_alias;
   wire logic [7:0] chan_ofs = paddr - tcm_pkg::OFS_CHANNEL_BASE;
   wire logic [1:0] chan_sel = chan_ofs[6:5];
   wire logic [4:0] chan_reg = {chan_ofs[4:2], 2'b00};
   wire logic chan_ok = chan_reg < tcm_pkg::CH_ALIAS;
   wire logic [3:0] alias_idx = paddr[5:2];
   wire logic [1:0] wval = pwdata[1:0];
   wire logic wval_ok = (pwdata[31:2] == 30'h0) && (wval == tcm_pkg::VAL_OFF ||
                                                    wval == tcm_pkg::VAL_ON);

   // All aliases share one window at the top of the map, four words per channel.
   wire logic [RW-1:0] limit_sel = limit_reg[chan_sel];
   wire logic [RW-1:0] rate_sel = rate_s[chan_sel*RW +: RW];

   // Derived status.
   logic [RW+1:0] rate_sum;
   logic [3:0] rate_over;
   always_comb begin
      rate_sum = '0;
      for (int i = 0; i < tcm_pkg::NUM_CHANNELS; i++) begin
         rate_sum = rate_sum + (RW+2)'(rate_s[i*RW +: RW]);
         rate_over[i] = IS_COMBINER && (rate_s[i*RW +: RW] > limit_reg[i]);
      end
   end
   wire logic major_c = IS_COMBINER ? (rate_sum > tcm_pkg::TOTAL_RATE_LIMIT)
                                    : dmajor_s;
   wire logic minor_c = (present_s == 4'h0);
   wire logic [2:0] alarm_code = major_c && minor_c ? tcm_pkg::BOTH_ALARM_CLASSES_ACTIVE :
                                 major_c ? tcm_pkg::MAJOR_CLASS_ACTIVE :
                                 minor_c ? tcm_pkg::MINOR_CLASS_ACTIVE :
                                 tcm_pkg::ALARM_FREE;
   wire logic [1:0] coding_code = !switch_b[1] ? tcm_pkg::CODING_MARK_INVERSION :
                                  switch_b[0] ? tcm_pkg::INVERTED_LEVEL_CODING :
                                  tcm_pkg::PLAIN_LEVEL_CODING;

   // Read mux.
   logic [31:0] chan_word;
   always_comb begin
      case (chan_reg)
         tcm_pkg::CH_PRESENCE: chan_word = 32'(tcm_pkg::two_state(present_s[chan_sel]));
         tcm_pkg::CH_ENABLE: chan_word = 32'(tcm_pkg::two_state(enable_reg[chan_sel]));
         tcm_pkg::CH_PACKET: chan_word = 32'(long_s[chan_sel] ? tcm_pkg::LONG_PACKET_LENGTH
                                            : tcm_pkg::SHORT_PACKET_LENGTH);
         tcm_pkg::CH_RATE: chan_word = 32'(rate_sel);
         tcm_pkg::CH_RATE_LIMIT: chan_word = 32'(limit_sel);
         tcm_pkg::CH_RATE_ALARM: chan_word = 32'(tcm_pkg::two_state(rate_over[chan_sel]));
         default: chan_word = 32'h0000_0000;
      endcase
   end
   logic [31:0] read_word;
   logic read_ok;
   always_comb begin
      read_ok = 1'b1;
      read_word = 32'h0000_0000;
      if (is_alias) begin
         read_word = alias_mem[alias_idx];
      end else if (in_chan) begin
         read_ok = chan_ok;
         read_word = chan_word;
      end else begin
         case (paddr)
            tcm_pkg::OFS_ALARM_SUMMARY: read_word = 32'(alarm_code);
            tcm_pkg::OFS_CAPPING: read_word = 32'(tcm_pkg::two_state(capping));
            tcm_pkg::OFS_CODING: read_word = 32'(coding_code);
            tcm_pkg::OFS_VERSION: read_word = {16'h0000, VERSION_MAJOR, VERSION_MINOR};
            tcm_pkg::OFS_UNIT_RESET: read_word = 32'h0000_0000;
            tcm_pkg::OFS_TRAP_ENABLE: read_word = {26'h0, trap_en[2], trap_en[1], trap_en[0]};
            tcm_pkg::OFS_TRAP_EVENTS: read_word = 32'(trap_events);
            tcm_pkg::OFS_TRUNK: read_word = 32'(tcm_pkg::two_state(trunk_s));
            default: read_ok = 1'b0;
         endcase
      end
   end

   // Writes; settings persist until rewritten or reset.
   wire logic wr_top = wr_fire && !in_chan;
   wire logic wr_ch = wr_fire && in_chan;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= '1;
         capping <= 1'b0;
         for (int i = 0; i < tcm_pkg::NUM_CHANNELS; i++) begin
            limit_reg[i] <= tcm_pkg::RESET_RATE_LIMIT;
         end
         for (int k = 0; k < 3; k++) begin
            trap_en[k] <= tcm_pkg::RESET_TRAP;
         end
      end else begin
         if (wr_ch && chan_reg == tcm_pkg::CH_ENABLE && wval_ok) begin
            enable_reg[chan_sel] <= (wval == tcm_pkg::VAL_ON);
         end
         if (IS_COMBINER && wr_ch && chan_reg == tcm_pkg::CH_RATE_LIMIT) begin
            limit_reg[chan_sel] <= pwdata[RW-1:0];
         end
         if (IS_COMBINER && wr_top && paddr == tcm_pkg::OFS_CAPPING && wval_ok) begin
            capping <= (wval == tcm_pkg::VAL_ON);
         end
         if (wr_top && paddr == tcm_pkg::OFS_TRAP_ENABLE) begin
            for (int k = 0; k < 3; k++) begin
               if (pwdata[2*k +: 2] == tcm_pkg::VAL_OFF || pwdata[2*k +: 2] == tcm_pkg::VAL_ON)
                  trap_en[k] <= pwdata[2*k +: 2];
            end
         end
      end
   end

   // Alias store; the top byte of the last word is forced to zero so 15 bytes fit.
   always_ff @(posedge pclk) begin
      if (wr_fire && is_alias) begin
         alias_mem[alias_idx] <= paddr[3:2] == tcm_pkg::ALIAS_WORD_FIELD ?
                                 {8'h00, pwdata[23:0]} : pwdata;
      end
   end

   // Unit reset pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_count <= '0;
      end else if (wr_top && paddr == tcm_pkg::OFS_UNIT_RESET
                   && pwdata == tcm_pkg::UNIT_RESET_KEY) begin
         reset_count <= 5'(tcm_pkg::UNIT_RESET_CYCLES);
      end else if (reset_count != 5'h00) begin
         reset_count <= reset_count - 5'h01;
      end
   end
   assign unit_reset = (reset_count != 5'h00);

   // Trap events.
   wire logic alarm_chg;
   wire logic rate_chg;
   wire logic pres_chg;
   tcm_change_detect #(.WIDTH(2)) u_alarm_chg (
      .pclk(pclk), .presetn(presetn), .level({major_c, minor_c}), .changed(alarm_chg));
   tcm_change_detect #(.WIDTH(4)) u_rate_chg (
      .pclk(pclk), .presetn(presetn), .level(rate_over), .changed(rate_chg));
   tcm_change_detect #(.WIDTH(4)) u_pres_chg (
      .pclk(pclk), .presetn(presetn), .level(present_s), .changed(pres_chg));
   wire logic [2:0] next_trap = {
      pres_chg && trap_en[2] == tcm_pkg::VAL_ON,
      rate_chg && IS_COMBINER && trap_en[1] == tcm_pkg::VAL_ON,
      alarm_chg && trap_en[0] == tcm_pkg::VAL_ON};
   wire logic clr_events = wr_top && paddr == tcm_pkg::OFS_TRAP_EVENTS;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_pulse <= '0;
         trap_events <= '0;
      end else begin
         trap_pulse <= next_trap;
         trap_events <= (clr_events ? trap_events & ~pwdata[2:0] : trap_events) | next_trap;
      end
   end

   // Panel indicators and outputs.
   wire logic flash_phase;
   tcm_flash_divider #(.HALF_CYCLES(FLASH_HALF_CYCLES)) u_flash (
      .pclk(pclk), .presetn(presetn), .phase(flash_phase));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_led <= '0;
         major_alarm <= 1'b0;
         minor_alarm <= 1'b0;
         prdata <= '0;
      end else begin
         for (int i = 0; i < tcm_pkg::NUM_CHANNELS; i++) begin
            channel_led[i] <= present_s[i] && (enable_reg[i] || flash_phase);
         end
         major_alarm <= major_c;
         minor_alarm <= minor_c;
         if (psel && !penable) begin
            prdata <= read_word;
         end
      end
   end
   assign channel_carry = enable_reg;
   assign capping_on = capping;
   for (genvar g = 0; g < tcm_pkg::NUM_CHANNELS; g++) begin : g_lim
      assign channel_rate_limit[g*RW +: RW] = limit_reg[g];
   end
   assign pready = psel && penable;
   assign pslverr = psel && penable && !read_ok;

   // Checks.
   unit_reset_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == tcm_pkg::OFS_UNIT_RESET
      ##1 penable |-> prdata == 32'h0000_0000) else $error("unit reset read not zero");
   unit_reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_top && paddr == tcm_pkg::OFS_UNIT_RESET && pwdata == tcm_pkg::UNIT_RESET_KEY
      |=> unit_reset [*8]) else $error("unit reset not held");
   alarm_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      major_c && minor_c |-> alarm_code == 3'h4) else $error("alarm summary wrong");
   major_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
      IS_COMBINER && rate_sum > tcm_pkg::TOTAL_RATE_LIMIT |=> major_alarm)
      else $error("urgent alarm missed");
   minor_none_a: assert property (@(posedge pclk) disable iff (!presetn)
      present_s == 4'h0 |=> minor_alarm) else $error("non-urgent alarm missed");
   enable_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_ch |=> $stable(enable_reg)) else $error("enable changed without write");
   led_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
      !present_s[0] |=> !channel_led[0]) else $error("led lit without signal");
   trap_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      trap_en[0] == tcm_pkg::VAL_OFF |=> !trap_pulse[0]) else $error("alarm trap leaked");
   trap_pres_a: assert property (@(posedge pclk) disable iff (!presetn)
      pres_chg && trap_en[2] == tcm_pkg::VAL_ON |=> trap_pulse[2])
      else $error("presence trap missed");
   rate_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
      IS_COMBINER && rate_s[RW-1:0] > limit_reg[0] |-> rate_over[0])
      else $error("rate alarm missed");
   cap_write_c: cover property (@(posedge pclk) wr_top && paddr == tcm_pkg::OFS_CAPPING);
   reset_c: cover property (@(posedge pclk) unit_reset);
   flash_c: cover property (@(posedge pclk) present_s[0] && !enable_reg[0]);
   trap_c: cover property (@(posedge pclk) |trap_pulse);
endmodule
